// ---- pkg/amd_regs.vh ----
// Constants of the addressing-mode decoder: prebytes, opcode fields, flags.
// Assumes opcode bits [7:4] select the addressing mode, bits [3:0] the operation.
`ifndef AMD_REGS_VH
`define AMD_REGS_VH

// Prebytes
`define AMD_PRE_NONE   8'h00
`define AMD_PRE_Y      8'h90
`define AMD_PRE_IY     8'h91
`define AMD_PRE_IND    8'h92

// Addressing mode field
`define AMD_M_INH      4'h0
`define AMD_M_IMM      4'h1
`define AMD_M_SDIR     4'h2
`define AMD_M_LDIR     4'h3
`define AMD_M_IX0      4'h4
`define AMD_M_IXS      4'h5
`define AMD_M_IXL      4'h6
`define AMD_M_REL      4'h7
`define AMD_M_BTJ      4'h8
`define AMD_M_RELATIVE_CALL_OP    4'hB

// Operation field, memory-operand modes
`define AMD_OP_LD      4'h0
`define AMD_OP_CP      4'h1
`define AMD_OP_AND     4'h2
`define AMD_OP_OR      4'h3
`define AMD_OP_XOR     4'h4
`define AMD_OP_ADD     4'h5
`define AMD_OP_ADC     4'h6
`define AMD_OP_SUB     4'h7
`define AMD_OP_SBC     4'h8
`define AMD_OP_BCP     4'h9
`define AMD_OP_LDX     4'hA

// Operation field, inherent mode
`define AMD_IN_NOP     4'h0
`define AMD_IN_SCF     4'h1
`define AMD_IN_RCF     4'h2
`define AMD_IN_SIM     4'h3
`define AMD_IN_RIM     4'h4

// Condition field, relative mode
`define AMD_JR_ALWAYS  4'h0
`define AMD_JR_NEVER   4'h1
`define AMD_JR_H1      4'h2
`define AMD_JR_H0      4'h3
`define AMD_JR_I1      4'h4
`define AMD_JR_I0      4'h5
`define AMD_JR_N1      4'h6
`define AMD_JR_N0      4'h7
`define AMD_JR_Z1      4'h8
`define AMD_JR_Z0      4'h9
`define AMD_JR_C1      4'hA
`define AMD_JR_C0      4'hB
`define AMD_JR_UGT     4'hC
`define AMD_JR_ULE     4'hD
`define AMD_JR_IRQ_HI  4'hE
`define AMD_JR_IRQ_LO  4'hF

// Condition-code bit positions
`define AMD_CC_H       4
`define AMD_CC_I       3
`define AMD_CC_N       2
`define AMD_CC_Z       1
`define AMD_CC_C       0

// Reset values and address constants
`define AMD_RST_PC     16'h0000
`define AMD_RST_CC     5'h08
`define AMD_RST_BYTE   8'h00
`define AMD_RST_WORD   16'h0000
`define AMD_PAGE0      8'h00
`define AMD_PC_STEP    16'h0001

`endif

// ---- logic/amd_alu.v ----
// Accumulator ALU for the memory-operand instructions.
// Assumes the caller applies the result and flags only as the update outputs say.
`timescale 1ns/1ps
`include "amd_regs.vh"

module amd_alu (
  input  wire [3:0] op,
  input  wire [7:0] a,
  input  wire [7:0] d,
  input  wire       cin,
  output reg  [7:0] res,
  output reg        wr_acc,
  output reg        upd_nz,
  output reg        upd_h,
  output reg        upd_c,
  output reg        h,
  output reg        c,
  output wire       n,
  output wire       z
);
  reg       cu;
  reg       bu;
  reg [8:0] sum;
  reg [4:0] hs;
  reg [8:0] dif;

  always @* begin
    cu     = (op == `AMD_OP_ADC) ? cin : 1'b0;
    bu     = (op == `AMD_OP_SBC) ? cin : 1'b0;
    sum    = {1'b0, a} + {1'b0, d} + {8'h00, cu};
    hs     = {1'b0, a[3:0]} + {1'b0, d[3:0]} + {4'h0, cu};
    dif    = {1'b0, a} - {1'b0, d} - {8'h00, bu};
    res    = a;
    wr_acc = 1'b0;
    upd_nz = 1'b1;
    upd_h  = 1'b0;
    upd_c  = 1'b0;
    h      = hs[4];
    c      = 1'b0;
    case (op)
      `AMD_OP_LD:  begin res = d; wr_acc = 1'b1; end
      `AMD_OP_CP:  begin res = dif[7:0]; upd_c = 1'b1; c = dif[8]; end
      `AMD_OP_AND: begin res = a & d; wr_acc = 1'b1; end
      `AMD_OP_OR:  begin res = a | d; wr_acc = 1'b1; end
      `AMD_OP_XOR: begin res = a ^ d; wr_acc = 1'b1; end
      `AMD_OP_ADD, `AMD_OP_ADC: begin
        res = sum[7:0];
        wr_acc = 1'b1;
        upd_h = 1'b1;
        upd_c = 1'b1;
        c = sum[8];
      end
      `AMD_OP_SUB, `AMD_OP_SBC: begin
        res = dif[7:0];
        wr_acc = 1'b1;
        upd_c = 1'b1;
        c = dif[8];
      end
      `AMD_OP_BCP: res = a & d;
      `AMD_OP_LDX: res = d;
      default:     upd_nz = 1'b0;
    endcase
  end

  assign n = res[7];
  assign z = (res == `AMD_RST_BYTE);
endmodule

// ---- logic/amd_core.v ----
// Instruction fetch, prebyte handling, effective address and execute sequencer.
// Assumes mem_rdata is valid, combinationally from mem_addr_reg, while mem_rd_reg is high.
`timescale 1ns/1ps
`include "amd_regs.vh"

// Function
// - Short direct: one address byte, page zero
// - Long direct: two address bytes, full space
// - Indexed address is unsigned index plus offset
// - No-offset indexed fetches no operand byte
// - Short indexed: byte offset, reach to 1FE
// - Long indexed: word offset plus index
// - Short indirect: byte pointer from page zero
// - Long indirect: word pointer via page-zero address
// - Indirect indexed: pointer value plus index
// - Short indirect indexed: byte pointer plus index
// - Relative: PC plus sign-extended 8-bit offset
// - Relative offset follows opcode or via pointer
// - ALU ops support immediate and all five memory forms
// - Prebyte, opcode, zero to two operand bytes
// - Prebyte 90 swaps first index for second
// - Prebyte 92 selects indirect forms
// - Prebyte 91 gives second-index indirect indexed
// - Opcode space decoded, extended by prebytes
// - Bit compare: AND, flags N Z only
// - Bit test branch on bit, bit to carry
// - Branches on interrupt line high or low
// - Single-flag branches and unsigned greater
module amd_core (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [7:0]  mem_rdata,
  input  wire        irq_line,
  output reg  [15:0] mem_addr_reg,
  output reg         mem_rd_reg,
  output reg  [15:0] pc_reg,
  output reg  [7:0]  acc_reg,
  output reg  [7:0]  x_reg,
  output reg  [7:0]  y_reg,
  output reg  [4:0]  cc_reg,
  output reg  [15:0] ea_reg,
  output reg  [15:0] ret_addr_reg,
  output reg         call_rel_reg,
  output reg         instr_done_reg
);
  localparam [3:0] S_FETCH = 4'h0;
  localparam [3:0] S_OPC   = 4'h1;
  localparam [3:0] S_OPND  = 4'h2;
  localparam [3:0] S_OPNDD = 4'h3;
  localparam [3:0] S_PTR   = 4'h4;
  localparam [3:0] S_PTRD  = 4'h5;
  localparam [3:0] S_RD    = 4'h6;
  localparam [3:0] S_RDD   = 4'h7;
  localparam [3:0] S_EX    = 4'h8;

  reg [3:0]  state_reg;
  reg [7:0]  pre_reg;
  reg [7:0]  opc_reg;
  reg [15:0] opb_reg;
  reg [15:0] ptr_reg;
  reg [7:0]  dat_reg;
  reg [1:0]  cnt_reg;
  reg        pcnt_reg;
  reg        irq_s1_reg;
  reg        irq_s2_reg;

  // Decode from the byte in flight while it is being taken as the opcode
  wire [7:0] cur_opc = (state_reg == S_OPC) ? mem_rdata : opc_reg;
  wire [3:0] mode    = cur_opc[7:4];
  wire [3:0] op      = cur_opc[3:0];

  function is_ind;
    input [7:0] pre;
    input [3:0] m;
    begin
      case (pre)
        `AMD_PRE_IND: is_ind = (m == `AMD_M_SDIR) || (m == `AMD_M_LDIR) ||
                               (m == `AMD_M_IXS) || (m == `AMD_M_IXL) ||
                               (m == `AMD_M_REL) || (m == `AMD_M_BTJ) ||
                               (m == `AMD_M_RELATIVE_CALL_OP);
        `AMD_PRE_IY:  is_ind = (m == `AMD_M_IXS) || (m == `AMD_M_IXL);
        default:      is_ind = 1'b0;
      endcase
    end
  endfunction

  function [1:0] opnd_count;
    input [3:0] m;
    input       ind;
    begin
      case (m)
        `AMD_M_IMM, `AMD_M_SDIR, `AMD_M_IXS,
        `AMD_M_REL, `AMD_M_RELATIVE_CALL_OP: opnd_count = 2'h1;
        `AMD_M_LDIR, `AMD_M_IXL:  opnd_count = ind ? 2'h1 : 2'h2;
        `AMD_M_BTJ:               opnd_count = 2'h2;
        default:                  opnd_count = 2'h0;
      endcase
    end
  endfunction

  function cond_true;
    input [3:0] k;
    input [4:0] f;
    input       irq;
    begin
      case (k)
        `AMD_JR_ALWAYS: cond_true = 1'b1;
        `AMD_JR_NEVER:  cond_true = 1'b0;
        `AMD_JR_H1:     cond_true = f[`AMD_CC_H];
        `AMD_JR_H0:     cond_true = ~f[`AMD_CC_H];
        `AMD_JR_I1:     cond_true = f[`AMD_CC_I];
        `AMD_JR_I0:     cond_true = ~f[`AMD_CC_I];
        `AMD_JR_N1:     cond_true = f[`AMD_CC_N];
        `AMD_JR_N0:     cond_true = ~f[`AMD_CC_N];
        `AMD_JR_Z1:     cond_true = f[`AMD_CC_Z];
        `AMD_JR_Z0:     cond_true = ~f[`AMD_CC_Z];
        `AMD_JR_C1:     cond_true = f[`AMD_CC_C];
        `AMD_JR_C0:     cond_true = ~f[`AMD_CC_C];
        `AMD_JR_UGT:    cond_true = ~(f[`AMD_CC_C] | f[`AMD_CC_Z]);
        `AMD_JR_ULE:    cond_true = f[`AMD_CC_C] | f[`AMD_CC_Z];
        `AMD_JR_IRQ_HI: cond_true = irq;
        `AMD_JR_IRQ_LO: cond_true = ~irq;
        default:        cond_true = 1'b0;
      endcase
    end
  endfunction

  wire       ind      = is_ind(pre_reg, mode);
  wire       use_y    = (pre_reg == `AMD_PRE_Y) || (pre_reg == `AMD_PRE_IY);
  wire [7:0] idx      = use_y ? y_reg : x_reg;
  wire       wide     = (mode == `AMD_M_LDIR) || (mode == `AMD_M_IXL);
  wire       indexed  = (mode == `AMD_M_IX0) || (mode == `AMD_M_IXS) ||
                        (mode == `AMD_M_IXL);
  wire       needs_rd = (mode == `AMD_M_SDIR) || (mode == `AMD_M_LDIR) || indexed ||
                        (mode == `AMD_M_BTJ);
  wire       is_pre   = (mem_rdata == `AMD_PRE_Y) || (mem_rdata == `AMD_PRE_IY) ||
                        (mem_rdata == `AMD_PRE_IND);

  // Page-zero pointer address, and short address byte before indexing
  wire [7:0]  paddr   = (mode == `AMD_M_BTJ) ? opb_reg[15:8] : opb_reg[7:0];
  wire [7:0]  b8      = ind ? ptr_reg[7:0] : paddr;
  wire [15:0] bv      = (mode == `AMD_M_IX0) ? 16'h0000 :
                        wide ? (ind ? ptr_reg : opb_reg) : {`AMD_PAGE0, b8};
  wire [15:0] ea      = bv + (indexed ? {`AMD_PAGE0, idx} : 16'h0000);

  // Branch offset: inline byte, or fetched through the pointer
  wire [7:0]  rel_off = (ind && (mode != `AMD_M_BTJ)) ? ptr_reg[7:0] : opb_reg[7:0];
  wire [15:0] target  = pc_reg + {{8{rel_off[7]}}, rel_off};
  wire [7:0]  opnd    = (mode == `AMD_M_IMM) ? opb_reg[7:0] : dat_reg;
  wire        tbit    = dat_reg[op[3:1]];

  wire [3:0]  after_opnd = ind ? S_PTR : (needs_rd ? S_RD : S_EX);

  wire [7:0] alu_res;
  wire       alu_wr;
  wire       alu_upd_nz;
  wire       alu_upd_h;
  wire       alu_upd_c;
  wire       alu_h;
  wire       alu_c;
  wire       alu_n;
  wire       alu_z;

  amd_alu u_alu (
    .op     (op),
    .a      (acc_reg),
    .d      (opnd),
    .cin    (cc_reg[`AMD_CC_C]),
    .res    (alu_res),
    .wr_acc (alu_wr),
    .upd_nz (alu_upd_nz),
    .upd_h  (alu_upd_h),
    .upd_c  (alu_upd_c),
    .h      (alu_h),
    .c      (alu_c),
    .n      (alu_n),
    .z      (alu_z)
  );

  always @(posedge clk_sys) begin
    irq_s1_reg <= irq_line;
    irq_s2_reg <= irq_s1_reg;
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      state_reg      <= S_FETCH;
      pre_reg        <= `AMD_PRE_NONE;
      opc_reg        <= `AMD_RST_BYTE;
      opb_reg        <= `AMD_RST_WORD;
      ptr_reg        <= `AMD_RST_WORD;
      dat_reg        <= `AMD_RST_BYTE;
      cnt_reg        <= 2'h0;
      pcnt_reg       <= 1'b0;
      mem_addr_reg   <= `AMD_RST_PC;
      mem_rd_reg     <= 1'b0;
      pc_reg         <= `AMD_RST_PC;
      acc_reg        <= `AMD_RST_BYTE;
      x_reg          <= `AMD_RST_BYTE;
      y_reg          <= `AMD_RST_BYTE;
      cc_reg         <= `AMD_RST_CC;
      ea_reg         <= `AMD_RST_WORD;
      ret_addr_reg   <= `AMD_RST_PC;
      call_rel_reg   <= 1'b0;
      instr_done_reg <= 1'b0;
    end else begin
      mem_rd_reg     <= 1'b0;
      call_rel_reg   <= 1'b0;
      instr_done_reg <= 1'b0;
      case (state_reg)
        S_FETCH: begin
          mem_addr_reg <= pc_reg;
          mem_rd_reg   <= 1'b1;
          pc_reg       <= pc_reg + `AMD_PC_STEP;
          state_reg    <= S_OPC;
        end
        S_OPC: begin
          if (is_pre) begin
            pre_reg   <= mem_rdata;
            state_reg <= S_FETCH;
          end else begin
            opc_reg  <= mem_rdata;
            opb_reg  <= `AMD_RST_WORD;
            ptr_reg  <= `AMD_RST_WORD;
            pcnt_reg <= 1'b0;
            cnt_reg  <= opnd_count(mode, ind);
            if (opnd_count(mode, ind) == 2'h0)
              state_reg <= after_opnd;
            else
              state_reg <= S_OPND;
          end
        end
        S_OPND: begin
          mem_addr_reg <= pc_reg;
          mem_rd_reg   <= 1'b1;
          pc_reg       <= pc_reg + `AMD_PC_STEP;
          state_reg    <= S_OPNDD;
        end
        S_OPNDD: begin
          opb_reg <= {opb_reg[7:0], mem_rdata};
          cnt_reg <= cnt_reg - 2'h1;
          if (cnt_reg == 2'h1)
            state_reg <= after_opnd;
          else
            state_reg <= S_OPND;
        end
        S_PTR: begin
          mem_addr_reg <= {`AMD_PAGE0, paddr + {7'h00, pcnt_reg}};
          mem_rd_reg   <= 1'b1;
          state_reg    <= S_PTRD;
        end
        S_PTRD: begin
          ptr_reg <= {ptr_reg[7:0], mem_rdata};
          if (wide && !pcnt_reg) begin
            pcnt_reg  <= 1'b1;
            state_reg <= S_PTR;
          end else if (needs_rd) begin
            state_reg <= S_RD;
          end else begin
            state_reg <= S_EX;
          end
        end
        S_RD: begin
          mem_addr_reg <= ea;
          mem_rd_reg   <= 1'b1;
          ea_reg       <= ea;
          state_reg    <= S_RDD;
        end
        S_RDD: begin
          dat_reg   <= mem_rdata;
          state_reg <= S_EX;
        end
        S_EX: begin
          instr_done_reg <= 1'b1;
          pre_reg        <= `AMD_PRE_NONE;
          state_reg      <= S_FETCH;
          case (mode)
            `AMD_M_INH: begin
              case (op)
                `AMD_IN_SCF: cc_reg[`AMD_CC_C] <= 1'b1;
                `AMD_IN_RCF: cc_reg[`AMD_CC_C] <= 1'b0;
                `AMD_IN_SIM: cc_reg[`AMD_CC_I] <= 1'b1;
                `AMD_IN_RIM: cc_reg[`AMD_CC_I] <= 1'b0;
                default: ;
              endcase
            end
            `AMD_M_IMM, `AMD_M_SDIR, `AMD_M_LDIR,
            `AMD_M_IX0, `AMD_M_IXS, `AMD_M_IXL: begin
              if (alu_wr)
                acc_reg <= alu_res;
              if ((op == `AMD_OP_LDX) && use_y)
                y_reg <= alu_res;
              if ((op == `AMD_OP_LDX) && !use_y)
                x_reg <= alu_res;
              if (alu_upd_nz) begin
                cc_reg[`AMD_CC_N] <= alu_n;
                cc_reg[`AMD_CC_Z] <= alu_z;
              end
              if (alu_upd_h)
                cc_reg[`AMD_CC_H] <= alu_h;
              if (alu_upd_c)
                cc_reg[`AMD_CC_C] <= alu_c;
            end
            `AMD_M_REL: begin
              if (cond_true(op, cc_reg, irq_s2_reg))
                pc_reg <= target;
            end
            `AMD_M_RELATIVE_CALL_OP: begin
              ret_addr_reg <= pc_reg;
              call_rel_reg <= 1'b1;
              pc_reg       <= target;
            end
            `AMD_M_BTJ: begin
              cc_reg[`AMD_CC_C] <= tbit;
              if (tbit == op[0])
                pc_reg <= target;
            end
            default: ;
          endcase
        end
        default: state_reg <= S_FETCH;
      endcase
    end
  end
endmodule

// ---- dv/amd_core_asserts.sv ----
// Port-level checks on the addressing-mode decoder core.
// Assumes it is bound onto amd_core; one clock, synchronous active-high reset.
`timescale 1ns/1ps

module amd_core_asserts (
  input wire        clk_sys,
  input wire        rst,
  input wire [7:0]  mem_rdata,
  input wire        irq_line,
  input wire [15:0] mem_addr_reg,
  input wire        mem_rd_reg,
  input wire [15:0] pc_reg,
  input wire [7:0]  acc_reg,
  input wire [7:0]  x_reg,
  input wire [7:0]  y_reg,
  input wire [4:0]  cc_reg,
  input wire [15:0] ea_reg,
  input wire [15:0] ret_addr_reg,
  input wire        call_rel_reg,
  input wire        instr_done_reg
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  rd_gap_a: assert property (mem_rd_reg |=> !mem_rd_reg)
    else $error("read strobes back to back");
  done_min_a: assert property (instr_done_reg |=> !instr_done_reg [*2])
    else $error("instructions retired too close");
  done_max_a: assert property (instr_done_reg |-> ##[3:20] instr_done_reg)
    else $error("next instruction not retired in time");
  fetch_next_a: assert property (instr_done_reg |=>
    mem_rd_reg && mem_addr_reg == $past(pc_reg))
    else $error("fetch after retire not at pc");
  reset_fetch_a: assert property ($fell(rst) |-> ##[1:2]
    (mem_rd_reg && mem_addr_reg == 16'h0000))
    else $error("first fetch after reset missing");
  cc_hold_a: assert property (!instr_done_reg |-> $stable(cc_reg))
    else $error("flags changed outside retire");
  acc_hold_a: assert property (!instr_done_reg |->
    $stable(acc_reg) && $stable(x_reg) && $stable(y_reg))
    else $error("register changed outside retire");
  ea_read_a: assert property ($changed(ea_reg) |->
    mem_rd_reg && mem_addr_reg == ea_reg)
    else $error("operand address without matching read");
  call_pulse_a: assert property (call_rel_reg |=> !call_rel_reg)
    else $error("call pulse longer than one cycle");
  ret_set_a: assert property ($changed(ret_addr_reg) |-> call_rel_reg)
    else $error("return address changed without call");
endmodule

// ---- dv/amd_mem_model.sv ----
// Zero-wait program and data memory on the core's read port.
// Assumes the bench loads contents by hierarchy before reset is released.
`timescale 1ns/1ps

module amd_mem_model (
  input  wire        clk_sys,
  input  wire [15:0] mem_addr,
  input  wire        mem_rd,
  output wire [7:0]  mem_rdata
);
  reg [7:0] mem [0:65535];
  reg [7:0] last_q;
  integer   k;

  initial begin
    last_q = 8'h00;
    for (k = 0; k < 65536; k = k + 1) begin
      mem[k] = 8'h00;
    end
  end

  always @(posedge clk_sys) begin
    if (mem_rd) begin
      last_q <= mem[mem_addr];
    end
  end

  // Data only while strobed, otherwise inverted last byte
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
endmodule

// ---- dv/amd_core_tb_top.sv ----
// Self-checking bench: a program in the memory model, stepped one instruction at a time.
// Assumes amd_core, amd_mem_model and amd_core_asserts are compiled alongside.
`timescale 1ns/1ps

module amd_core_tb_top;
  localparam integer LIMIT = 2000;
  reg         clk_sys;
  reg         rst;
  reg         irq_line;
  wire [7:0]  mem_rdata;
  wire [15:0] mem_addr_reg;
  wire        mem_rd_reg;
  wire [15:0] pc_reg;
  wire [7:0]  acc_reg;
  wire [7:0]  x_reg;
  wire [7:0]  y_reg;
  wire [4:0]  cc_reg;
  wire [15:0] ea_reg;
  wire [15:0] ret_addr_reg;
  wire        call_rel_reg;
  wire        instr_done_reg;
  integer     error_cnt;
  integer     check_count;
  integer     cyc;
  integer     i;
  reg [783:0] prog;
  reg [431:0] dat;
  reg [279:0] ext;

  amd_core amd_core_i (
    .clk_sys(clk_sys), .rst(rst), .mem_rdata(mem_rdata), .irq_line(irq_line),
    .mem_addr_reg(mem_addr_reg), .mem_rd_reg(mem_rd_reg), .pc_reg(pc_reg),
    .acc_reg(acc_reg), .x_reg(x_reg), .y_reg(y_reg), .cc_reg(cc_reg), .ea_reg(ea_reg),
    .ret_addr_reg(ret_addr_reg), .call_rel_reg(call_rel_reg),
    .instr_done_reg(instr_done_reg)
  );

  amd_mem_model amd_mem_model_i (
    .clk_sys(clk_sys), .mem_addr(mem_addr_reg), .mem_rd(mem_rd_reg), .mem_rdata(mem_rdata)
  );

  always #2.5 clk_sys = ~clk_sys;

  task chk(input [15:0] seen, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task test_done;
    begin
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // Wait for the next retire, then compare accumulator, flags, pc and operand address
  task step(input [7:0] a, input [4:0] c, input [15:0] p, input [15:0] e);
    integer n;
    begin
      n = 0;
      @(posedge clk_sys);
      #1;
      while (instr_done_reg !== 1'b1 && n < 40) begin
        @(posedge clk_sys);
        #1;
        n = n + 1;
      end
      chk({15'h0000, instr_done_reg}, 16'h0001);
      chk({8'h00, acc_reg}, {8'h00, a});
      chk({11'h000, cc_reg}, {11'h000, c});
      chk(pc_reg, p);
      chk(ea_reg, e);
    end
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt = error_cnt + 1;
      test_done;
    end
  end

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    irq_line = 1'b1;
    error_cnt = 0;
    check_count = 0;
    cyc = 0;
    prog = {128'h1A10901A2010F0258035123416014090, 128'h50FF6012009220909230919250939160,
            128'h9419997802000079107C107003007004, 128'h7BFC0000017A010010017C01027C0100,
            128'h7E0200007F02047501008B8005000000, 128'h00008A80028880020000927096000000,
            16'hB010};
    // Address and byte pairs; words stored high byte first
    dat = {192'h008020_008133_009081_009156_009278_0093F0_009412_009534,
           192'h009603_010055_011F80_12340F_125466_567844_00727F_007302,
           48'h007670_007728};
    // Second block at 00A0: compare, logic, subtract and flag branches
    ext = {128'h11017D02000013F07602000014FF120C, 128'h170D18FE0374020000717F7202000073,
           24'h022181};
    #1;
    for (i = 0; i < 98; i = i + 1) begin
      amd_mem_model_i.mem[i] = prog[8*(97-i) +: 8];
    end
    for (i = 0; i < 18; i = i + 1) begin
      amd_mem_model_i.mem[dat[431-24*i -: 16]] = dat[415-24*i -: 8];
    end
    for (i = 0; i < 35; i = i + 1) begin
      amd_mem_model_i.mem[16'h00A0 + i] = ext[8*(34-i) +: 8];
    end
    repeat (20) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    step(8'h00, 5'h08, 16'h0002, 16'h0000);
    step(8'h00, 5'h08, 16'h0005, 16'h0000);
    chk({8'h00, x_reg}, 16'h0010);
    chk({8'h00, y_reg}, 16'h0020);
    step(8'hF0, 5'h0C, 16'h0007, 16'h0000);
    step(8'h10, 5'h09, 16'h0009, 16'h0080);
    step(8'h1F, 5'h08, 16'h000C, 16'h1234);
    step(8'h20, 5'h18, 16'h000E, 16'h1234);
    step(8'h50, 5'h18, 16'h000F, 16'h0010);
    step(8'h80, 5'h1C, 16'h0012, 16'h011F);
    step(8'h00, 5'h1A, 16'h0015, 16'h1210);
    step(8'h33, 5'h18, 16'h0018, 16'h0081);
    step(8'h44, 5'h18, 16'h001B, 16'h5678);
    step(8'h55, 5'h18, 16'h001E, 16'h0100);
    step(8'h66, 5'h18, 16'h0021, 16'h1254);
    step(8'h66, 5'h1A, 16'h0023, 16'h1254);
    step(8'h66, 5'h1A, 16'h0027, 16'h1254);
    step(8'h66, 5'h1A, 16'h0029, 16'h1254);
    step(8'h66, 5'h1A, 16'h002B, 16'h1254);
    step(8'h66, 5'h1A, 16'h0030, 16'h1254);
    step(8'h66, 5'h1A, 16'h002E, 16'h1254);
    step(8'h66, 5'h1A, 16'h0034, 16'h1254);
    step(8'h66, 5'h1B, 16'h0035, 16'h1254);
    step(8'h66, 5'h1B, 16'h0038, 16'h1254);
    step(8'h01, 5'h19, 16'h003A, 16'h1254);
    step(8'h01, 5'h19, 16'h003C, 16'h1254);
    step(8'h01, 5'h18, 16'h003D, 16'h1254);
    step(8'h01, 5'h18, 16'h0040, 16'h1254);
    step(8'h01, 5'h18, 16'h0044, 16'h1254);
    step(8'h01, 5'h18, 16'h0046, 16'h1254);
    step(8'h01, 5'h10, 16'h0047, 16'h1254);
    step(8'h01, 5'h10, 16'h004A, 16'h1254);
    step(8'h01, 5'h11, 16'h0052, 16'h0080);
    step(8'h01, 5'h11, 16'h0055, 16'h0080);
    step(8'h01, 5'h10, 16'h005A, 16'h0080);
    step(8'h01, 5'h10, 16'h0060, 16'h0080);
    step(8'h01, 5'h10, 16'h0072, 16'h0080);
    chk(ret_addr_reg, 16'h0062);
    chk({15'h0000, call_rel_reg}, 16'h0001);
    irq_line = 1'b0;
    step(8'h01, 5'h10, 16'h0076, 16'h0080);
    step(8'h01, 5'h10, 16'h00A0, 16'h0080);
    step(8'h01, 5'h12, 16'h00A2, 16'h0080);
    step(8'h01, 5'h12, 16'h00A6, 16'h0080);
    step(8'hF1, 5'h14, 16'h00A8, 16'h0080);
    step(8'hF1, 5'h14, 16'h00AC, 16'h0080);
    step(8'h0E, 5'h10, 16'h00AE, 16'h0080);
    step(8'h0C, 5'h10, 16'h00B0, 16'h0080);
    step(8'hFF, 5'h15, 16'h00B2, 16'h0080);
    step(8'h00, 5'h12, 16'h00B4, 16'h0080);
    step(8'h00, 5'h1A, 16'h00B5, 16'h0080);
    step(8'h00, 5'h1A, 16'h00B9, 16'h0080);
    step(8'h00, 5'h1A, 16'h00BB, 16'h0080);
    step(8'h00, 5'h1A, 16'h00BF, 16'h0080);
    step(8'h00, 5'h1A, 16'h00C1, 16'h0080);
    step(8'h00, 5'h1D, 16'h00C3, 16'h0081);
    test_done;
  end
endmodule

bind amd_core amd_core_asserts amd_core_asserts_i (
  .clk_sys(clk_sys), .rst(rst), .mem_rdata(mem_rdata), .irq_line(irq_line),
  .mem_addr_reg(mem_addr_reg), .mem_rd_reg(mem_rd_reg), .pc_reg(pc_reg),
  .acc_reg(acc_reg), .x_reg(x_reg), .y_reg(y_reg), .cc_reg(cc_reg), .ea_reg(ea_reg),
  .ret_addr_reg(ret_addr_reg), .call_rel_reg(call_rel_reg), .instr_done_reg(instr_done_reg)
);
